//--- mdf_core.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module mdf_core
  import mdf_pkg::*;
#(
  parameter int PLL_DIV = 8,
  parameter int DEPTH   = FIFO_DEPTH
) (
  // Clock, reset and enable.
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Register port.
  input  wire logic [7:0]       i_addr,
  input  wire logic [7:0]       i_wr_data,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic [7:0]            o_rd_data,
  // Clock source pins: relax, gyro x, y, z, ext 32.768 kHz, ext 19.2 MHz.
  input  wire logic [N_SRC-1:0] i_clk_src,
  // Sensor samples, X first, high byte first.
  input  wire logic [47:0]      i_gyro,
  input  wire logic [47:0]      i_accel,
  input  wire logic [47:0]      i_mag,
  input  wire logic [15:0]      i_temp,
  input  wire logic [63:0]      i_aux,
  input  wire logic             i_frame_sync_input,
  // Event sources.
  input  wire logic             i_motion_evt,
  input  wire logic             i_aux_nack,
  input  wire logic             i_aux_lost_arb,
  input  wire logic             i_slv4_done,
  // Interrupt pin.
  output logic                  o_int,
  output logic                  o_int_oe
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (PLL_DIV < 1 || PLL_DIV > 255) $error("PLL_DIV out of range");
    if (DEPTH > 2048) $error("DEPTH does not fit the count registers");
  end

  typedef struct packed {
    logic [2:0]          clk_sel;
    logic [4:0]          fifo_cfg;
    logic [3:0]          int_cfg;
    logic [IRQ_N-1:0]    int_en;
    logic [IRQ_N-1:0]    int_stat;
    logic [7:0]          div_cnt;
    logic [159:0]        sens;
    logic [63:0]         aux;
    logic                frame_sync_input;
    logic                fs_s1;
    logic                fs_s2;
    logic                walk_on;
    logic [4:0]          walk_idx;
    logic [7:0]          rd_data;
    logic [7:0]          pulse_cnt;
    logic                int_out;
    logic                int_oe;
  } mdf_core_state_t;
  mdf_core_state_t q, d;

  logic             src_edge;
  logic [2:0]       src_active;
  logic             src_switching;
  logic             tick;
  logic [7:0]       fifo_head;
  logic [AW:0]      fifo_cnt;
  logic             fifo_ovf;
  logic             fifo_pop;
  logic             fifo_push;
  logic [7:0]       push_byte;
  logic [183:0]     frame;
  logic [IRQ_N-1:0] ev;
  logic [IRQ_N-1:0] clr;
  logic             any_new;
  logic             asserted;
  logic             pin_level;

  // Byte idx of a vector, counted from its most significant byte.
  function automatic logic [7:0] sens_byte(input logic [159:0] v, input logic [7:0] idx);
    sens_byte = v[159 - 8*int'(idx) -: 8];
  endfunction

  function automatic logic [7:0] frame_byte(input logic [183:0] v, input logic [4:0] idx);
    frame_byte = v[183 - 8*int'(idx) -: 8];
  endfunction

  // Configuration bit that admits frame byte idx to the buffer.
  function automatic int frame_group(input logic [4:0] idx);
    if (idx < 5'd6) frame_group = FCFG_ACCEL;
    else if (idx < 5'd8) frame_group = FCFG_TEMP;
    else if (idx < 5'd14) frame_group = FCFG_GYRO;
    else if (idx < 5'd22) frame_group = FCFG_AUX;
    else frame_group = FCFG_FRAME_SYNC_INPUT;
  endfunction

  mdf_clk_sel u_clk_sel (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_src       (i_clk_src),
    .i_sel       (q.clk_sel),
    .o_edge      (src_edge),
    .o_active    (src_active),
    .o_switching (src_switching)
  );

  mdf_byte_fifo #(
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_push     (fifo_push),
    .i_data     (push_byte),
    .i_pop      (fifo_pop),
    .o_head     (fifo_head),
    .o_count    (fifo_cnt),
    .o_overflow (fifo_ovf)
  );

  // The divider turns selected source edges into the sample clock.
  assign tick = src_edge && (q.div_cnt == 8'(PLL_DIV - 1));

  // Frame layout: accel, temperature, gyro, auxiliary, frame-sync byte.
  assign frame = {q.sens[111:64], q.sens[63:48], q.sens[159:112], q.aux, 7'h00, q.frame_sync_input};
  assign push_byte = frame_byte(frame, q.walk_idx);
  assign fifo_push = q.walk_on && q.fifo_cfg[frame_group(q.walk_idx)];
  assign fifo_pop = i_rd && (i_addr == REG_FIFO_DATA);

  always_comb begin
    ev = '0;
    ev[IRQ_DRDY] = tick;
    ev[IRQ_OVF] = fifo_ovf;
    ev[IRQ_MST_ERR] = i_aux_nack || i_aux_lost_arb;
    ev[IRQ_SLV4] = i_slv4_done;
    ev[IRQ_MOTION] = i_motion_evt;
    clr = '0;
    if (i_rd && (i_addr == REG_INT_STATUS || q.int_cfg[ICFG_CLR_ANY])) clr = '1;
  end

  assign any_new = |(ev & q.int_en);
  assign asserted = q.int_cfg[ICFG_LATCH] ? |(q.int_stat & q.int_en)
                                          : (q.pulse_cnt != 8'h00);
  assign pin_level = q.int_cfg[ICFG_ACT_LOW] ? !asserted : asserted;

  always_comb begin
    d = q;
    d.fs_s1 = i_frame_sync_input;
    d.fs_s2 = q.fs_s1;

    // Register writes; status, counts and sensor data ignore writes.
    if (i_wr) begin
      unique case (i_addr)
        REG_CLK_SEL:  d.clk_sel = i_wr_data[2:0];
        REG_FIFO_CFG: d.fifo_cfg = i_wr_data[4:0];
        REG_INT_CFG:  d.int_cfg = i_wr_data[3:0];
        REG_INT_EN:   d.int_en = i_wr_data[IRQ_N-1:0];
        default:      d.clk_sel = q.clk_sel;
      endcase
    end

    // Register reads, answered in the following cycle.
    d.rd_data = 8'h00;
    if (i_rd) begin
      if (i_addr >= REG_SENS_FIRST && i_addr <= REG_SENS_LAST) begin
        d.rd_data = sens_byte(q.sens, i_addr - REG_SENS_FIRST);
      end else begin
        unique case (i_addr)
          REG_CLK_SEL:    d.rd_data = {5'h00, q.clk_sel};
          REG_FIFO_CFG:   d.rd_data = {3'h0, q.fifo_cfg};
          REG_INT_CFG:    d.rd_data = {4'h0, q.int_cfg};
          REG_INT_EN:     d.rd_data = {3'h0, q.int_en};
          REG_INT_STATUS: d.rd_data = {3'h0, q.int_stat};
          REG_FIFO_CNT_H: d.rd_data = 8'(fifo_cnt >> 8);
          REG_FIFO_CNT_L: d.rd_data = 8'(fifo_cnt);
          REG_FIFO_DATA:  d.rd_data = fifo_head;
          REG_CLK_STAT:   d.rd_data = {4'h0, src_switching, src_active};
          default:        d.rd_data = 8'h00;
        endcase
      end
    end

    // Sample clock divider and capture of the latest data.
    if (src_edge) begin
      d.div_cnt = tick ? 8'h00 : q.div_cnt + 8'h01;
    end
    if (tick) begin
      d.sens = {i_gyro, i_accel, i_temp, i_mag};
      d.aux = i_aux;
      d.frame_sync_input = q.fs_s2;
      d.walk_on = 1'b1; // A new sample restarts the frame walk.
      d.walk_idx = 5'd0;
    end else if (q.walk_on) begin
      if (q.walk_idx == 5'(FRAME_BYTES - 1)) d.walk_on = 1'b0;
      else d.walk_idx = q.walk_idx + 5'd1;
    end

    // Status flags: a new event wins over a clear in the same cycle.
    d.int_stat = (q.int_stat & ~clr) | ev;

    // Pulse mode stretches each enabled event to a fixed width.
    if (any_new) d.pulse_cnt = 8'(INT_PULSE_CYC);
    else if (q.pulse_cnt != 8'h00) d.pulse_cnt = q.pulse_cnt - 8'h01;

    // Open drain drives only the low level; push-pull always drives.
    if (q.int_cfg[ICFG_OPEN_DRN]) begin
      d.int_out = 1'b0;
      d.int_oe = !pin_level;
    end else begin
      d.int_out = pin_level;
      d.int_oe = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '0;
      q.clk_sel <= CLK_SEL_RST;
      q.fifo_cfg <= FIFO_CFG_RST;
      q.int_cfg <= INT_CFG_RST;
      q.int_en <= INT_EN_RST;
      q.int_oe <= 1'b1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_rd_data = q.rd_data;
  assign o_int = q.int_out;
  assign o_int_oe = q.int_oe;

  clk_reset_relax_a: assert property (@(posedge i_core_clk)
    $fell(i_rst) |-> q.clk_sel == CLK_SEL_RST && src_active == CLK_SEL_RST)
    else $error("source after reset is not the relaxation oscillator");


  sens_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_rd && i_addr == REG_SENS_FIRST |=> o_rd_data == $past(q.sens[159:152]))
    else $error("first sensor byte read back wrong");


  sens_write_ignored_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_wr && i_addr >= REG_SENS_FIRST && i_addr <= REG_SENS_LAST && !tick
    |=> q.sens == $past(q.sens)) else $error("sensor register took a write");


  drdy_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && tick |=> q.int_stat[IRQ_DRDY]) else $error("data ready flag not set");


  capture_latest_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && tick |=> q.sens[63:48] == $past(i_temp))
    else $error("sample not captured on the sample clock");


  disabled_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && q.int_en == '0 && q.int_cfg[ICFG_LATCH] |-> !asserted)
    else $error("interrupt asserted with every source disabled");


  latched_pin_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && q.int_cfg == 4'h2 && |(q.int_stat & q.int_en) |=> o_int && o_int_oe)
    else $error("latched push-pull pin not high with an active source");


  pop_count_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && fifo_pop && !fifo_push && fifo_cnt != '0 |=> fifo_cnt == $past(fifo_cnt) - 1'b1)
    else $error("buffer read did not drop the count by one");


  walk_len_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && tick ##1 (i_ce && !tick) [*8] |-> q.walk_on && q.walk_idx == 5'd7)
    else $error("frame walk does not advance one byte a cycle");

  rd_idle_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !i_rd |=> o_rd_data == 8'h00)
    else $error("read data not zero outside the answer cycle");

  set_beats_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && ev[IRQ_SLV4] |=> q.int_stat[IRQ_SLV4])
    else $error("status flag lost an event");

  status_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_rd && i_addr == REG_INT_STATUS && ev == '0 |=> q.int_stat == '0)
    else $error("status read did not clear the flags");

  pulse_start_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !i_wr && any_new && !q.int_cfg[ICFG_LATCH] |=> asserted)
    else $error("pulse mode did not start on an enabled event");

  open_drain_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && q.int_cfg[ICFG_OPEN_DRN] |=> !o_int && o_int_oe == !$past(pin_level))
    else $error("open-drain pin drove a high level");

  push_pull_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !q.int_cfg[ICFG_OPEN_DRN] |=> o_int_oe && o_int == $past(pin_level))
    else $error("push-pull pin level wrong");

  walk_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !q.walk_on |-> !fifo_push)
    else $error("buffer push outside a frame walk");

  tick_switch_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    src_switching |-> !tick)
    else $error("sample tick during source changeover");

  ovf_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && fifo_ovf |=> q.int_stat[IRQ_OVF])
    else $error("overflow flag not set");

  cnt_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_rd && i_addr == REG_FIFO_CNT_L |=> o_rd_data == 8'($past(fifo_cnt)))
    else $error("count low byte read back wrong");

  gyro_capture_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && tick |=> q.sens[159:112] == $past(i_gyro))
    else $error("gyro sample not captured");
endmodule

//--- mdf_pkg.sv
package mdf_pkg;

  // Register indices on the 8-bit register port.
  localparam logic [7:0] REG_CLK_SEL    = 8'h00;
  localparam logic [7:0] REG_FIFO_CFG   = 8'h01;
  localparam logic [7:0] REG_INT_CFG    = 8'h02;
  localparam logic [7:0] REG_INT_EN     = 8'h03;
  localparam logic [7:0] REG_INT_STATUS = 8'h04;
  localparam logic [7:0] REG_FIFO_CNT_H = 8'h05;
  localparam logic [7:0] REG_FIFO_CNT_L = 8'h06;
  localparam logic [7:0] REG_FIFO_DATA  = 8'h07;
  localparam logic [7:0] REG_CLK_STAT   = 8'h08;
  localparam logic [7:0] REG_SENS_FIRST = 8'h10;
  localparam logic [7:0] REG_SENS_LAST  = 8'h23;

  // Buffer configuration fields.
  localparam int FCFG_GYRO  = 0;
  localparam int FCFG_ACCEL = 1;
  localparam int FCFG_TEMP  = 2;
  localparam int FCFG_AUX   = 3;
  localparam int FCFG_FRAME_SYNC_INPUT = 4;

  // Interrupt configuration fields.
  localparam int ICFG_CLR_ANY  = 0;
  localparam int ICFG_LATCH    = 1;
  localparam int ICFG_OPEN_DRN = 2;
  localparam int ICFG_ACT_LOW  = 3;

  // Interrupt source positions in the enable and status registers.
  localparam int IRQ_DRDY    = 0;
  localparam int IRQ_OVF     = 1;
  localparam int IRQ_MST_ERR = 2;
  localparam int IRQ_SLV4    = 3;
  localparam int IRQ_MOTION  = 4;
  localparam int IRQ_N       = 5;

  // Reset values.
  localparam logic [2:0] CLK_SEL_RST  = 3'h0;
  localparam logic [4:0] FIFO_CFG_RST = 5'h00;
  localparam logic [3:0] INT_CFG_RST  = 4'h0;
  localparam logic [4:0] INT_EN_RST   = 5'h00;

  // Sizes.
  localparam int FIFO_DEPTH  = 1024;
  localparam int SENS_BYTES  = 20;
  localparam int FRAME_BYTES = 23;
  localparam int N_SRC       = 6;

  // Timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int INT_PULSE_NS  = 400;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SRC_RELAX, SRC_GYRO_X, SRC_GYRO_Y, SRC_GYRO_Z, SRC_EXT_32K, SRC_EXT_19M
  } mdf_src_t;

endpackage

//--- mdf_clk_sel.sv
`timescale 1ns/1ns
module mdf_clk_sel
  import mdf_pkg::*;
(
  // Clock and reset.
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // Raw source pins and selection.
  input  wire logic [N_SRC-1:0] i_src,
  input  wire logic [2:0]       i_sel,
  // Selected source edges, active source and changeover flag.
  output logic                  o_edge,
  output logic [2:0]            o_active,
  output logic                  o_switching
);
  typedef enum logic [1:0] {CS_RUN, CS_WAIT_OLD, CS_WAIT_NEW} mdf_cs_t;
  typedef struct packed {
    logic [N_SRC-1:0] s1;
    logic [N_SRC-1:0] s2;
    logic [N_SRC-1:0] prev;
    logic [2:0]       cur;
    logic [2:0]       nxt;
    mdf_cs_t          st;
  } mdf_cs_state_t;
  mdf_cs_state_t q, d;
  logic [2:0] sel_ok;

  // Unused codes fall back to the relaxation oscillator.
  assign sel_ok = (int'(i_sel) < N_SRC) ? i_sel : CLK_SEL_RST;

  always_comb begin
    d = q;
    d.s1 = i_src;
    d.s2 = q.s1;
    d.prev = q.s2;
    unique case (q.st)
      CS_RUN: begin
        if (sel_ok != q.cur) begin
          d.nxt = sel_ok;
          d.st = CS_WAIT_OLD;
        end
      end
      CS_WAIT_OLD: begin
        // Hand over only after the old source has fallen, so no high phase is cut short.
        if (q.prev[q.cur] && !q.s2[q.cur]) d.st = CS_WAIT_NEW;
      end
      CS_WAIT_NEW: begin
        if (q.prev[q.nxt] && !q.s2[q.nxt]) begin
          d.cur = q.nxt;
          d.st = CS_RUN;
        end
      end
    endcase
  end

  assign o_edge = (q.st == CS_RUN) && !q.prev[q.cur] && q.s2[q.cur];
  assign o_active = q.cur;
  assign o_switching = (q.st != CS_RUN);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '{s1: '0, s2: '0, prev: '0, cur: CLK_SEL_RST, nxt: CLK_SEL_RST, st: CS_RUN};
    end else if (i_ce) begin
      q <= d;
    end
  end

  no_edge_switch_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_switching |-> !o_edge) else $error("source edge passed during changeover");
endmodule

//--- mdf_byte_fifo.sv
`timescale 1ns/1ns
module mdf_byte_fifo
  import mdf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_ce,
  // Fill and drain.
  input  wire logic                     i_push,
  input  wire logic [7:0]               i_data,
  input  wire logic                     i_pop,
  output logic [7:0]                    o_head,
  output logic [$clog2(DEPTH):0]        o_count,
  output logic                          o_overflow
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          ovf;
  } mdf_fifo_state_t;
  mdf_fifo_state_t q, d;
  logic [7:0] mem [DEPTH];
  logic       full;
  logic       do_pop;

  assign full = (q.cnt == (AW+1)'(DEPTH));
  assign do_pop = i_pop && (q.cnt != '0);

  always_comb begin
    d = q;
    d.ovf = 1'b0;
    if (i_push) begin
      d.wr = q.wr + 1'b1;
      if (do_pop) begin
        d.rd = q.rd + 1'b1;
      end else if (full) begin
        d.rd = q.rd + 1'b1;
        d.ovf = 1'b1;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end else if (do_pop) begin
      d.rd = q.rd + 1'b1;
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_ce && i_push) mem[q.wr] <= i_data;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_head = (q.cnt != '0) ? mem[q.rd] : 8'h00;
  assign o_count = q.cnt;
  assign o_overflow = q.ovf;

  full_stays_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && full && i_push && !i_pop |=> full && o_overflow)
    else $error("overflowing push did not keep the buffer full");
  count_bound_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    q.cnt <= (AW+1)'(DEPTH)) else $error("byte count above depth");
endmodule

//--- mdf_src_model.sv
`timescale 1ns/1ns
module mdf_src_model (
  // Run control.
  input  wire logic i_run,
  // Clock-source pins.
  output logic [5:0] o_src
);
  int t;

  initial begin
    t = 0;
    o_src = '0;
  end

  // Each pin is a 64 ns square wave with its own phase; all stand low while stopped.
  always #1 begin
    t = t + 1;
    for (int k = 0; k < 6; k++) begin
      o_src[k] = i_run & ((((t + 5 * k) / 32) % 2) == 1);
    end
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top
  import mdf_pkg::*;
;
  localparam int PDIV = 4;
  localparam int DEP  = 16;

  logic         i_core_clk;
  logic         i_rst;
  logic         ce;
  logic [7:0]   i_addr;
  logic [7:0]   i_wr_data;
  logic         i_wr;
  logic         i_rd;
  logic [7:0]   o_rd_data;
  logic [5:0]   clk_src;
  logic         src_run;
  logic [47:0]  i_gyro;
  logic [47:0]  i_accel;
  logic [47:0]  i_mag;
  logic [15:0]  i_temp;
  logic [63:0]  i_aux;
  logic         i_frame_sync_input;
  logic [3:0]   evt;
  logic         o_int;
  logic         o_int_oe;
  int           num_errors;
  int           cmp_count;
  int           cyc;
  logic [7:0]   rd;
  logic [159:0] sens;
  int           fbt [5];

  mdf_core #(.PLL_DIV(PDIV), .DEPTH(DEP)) dut (
    .i_core_clk        (i_core_clk),
    .i_rst             (i_rst),
    .i_ce              (ce),
    .i_addr            (i_addr),
    .i_wr_data         (i_wr_data),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .o_rd_data         (o_rd_data),
    .i_clk_src         (clk_src),
    .i_gyro            (i_gyro),
    .i_accel           (i_accel),
    .i_mag             (i_mag),
    .i_temp            (i_temp),
    .i_aux             (i_aux),
    .i_frame_sync_input(i_frame_sync_input),
    .i_motion_evt      (evt[1]),
    .i_aux_nack        (evt[2]),
    .i_aux_lost_arb    (evt[3]),
    .i_slv4_done       (evt[0]),
    .o_int             (o_int),
    .o_int_oe          (o_int_oe)
  );

  mdf_src_model src (
    .i_run(src_run),
    .o_src(clk_src)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    d = o_rd_data;
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    cmp8(d, exp);
  endtask

  task automatic pulse(input int k);
    @(posedge i_core_clk);
    evt[k] <= 1'b1;
    @(posedge i_core_clk);
    evt <= '0;
  endtask

  function automatic logic [63:0] grp_val(input int g);
    case (g)
      0: return {i_gyro, 16'h0000};
      1: return {i_accel, 16'h0000};
      2: return {i_temp, 48'h0000_0000_0000};
      3: return i_aux;
      default: return 64'h0100_0000_0000_0000;
    endcase
  endfunction

  initial begin
    int fb;
    int off;
    logic [63:0] gv;
    num_errors = 0;
    cmp_count = 0;
    cyc = 0;
    fbt = '{6, 6, 2, 8, 1};
    i_rst = 1'b1;
    ce = 1'b1;
    i_addr = 8'h00;
    i_wr_data = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    src_run = 1'b0;
    evt = '0;
    i_gyro = 48'h1122_3344_5566;
    i_accel = 48'h7788_99AA_BBCC;
    i_temp = 16'hDDEE;
    i_mag = 48'h0102_0304_0506;
    i_aux = 64'hA1A2_A3A4_A5A6_A7A8;
    i_frame_sync_input = 1'b1;
    sens = {i_gyro, i_accel, i_temp, i_mag};
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    for (int a = 0; a <= 8; a++) begin
      chk(8'(a), 8'h00);
    end
    chk(8'h30, 8'h00);
    src_run <= 1'b1;
    for (int s = 5; s >= 0; s--) begin
      wr(REG_CLK_SEL, 8'(s));
      settle(100);
      chk(REG_CLK_STAT, 8'(s));
    end
    settle(200);
    src_run <= 1'b0;
    settle(60);
    for (int k = 0; k < SENS_BYTES; k++) begin
      chk(8'(REG_SENS_FIRST + k), sens[159 - 8 * k -: 8]);
    end
    wr(REG_SENS_FIRST, 8'hFF);
    chk(REG_SENS_FIRST, sens[159 -: 8]);
    chk(REG_INT_STATUS, 8'h01);
    for (int g = 0; g < 5; g++) begin
      fb = fbt[g];
      off = (fb - (DEP % fb)) % fb;
      gv = grp_val(g);
      wr(REG_FIFO_CFG, 8'(1 << g));
      src_run <= 1'b1;
      settle(800);
      src_run <= 1'b0;
      settle(60);
      wr(REG_FIFO_CFG, 8'h00);
      chk(REG_FIFO_CNT_H, 8'h00);
      chk(REG_FIFO_CNT_L, 8'(DEP));
      rd_reg(REG_INT_STATUS, rd);
      cmp8({7'h0, rd[IRQ_OVF]}, 8'h01);
      for (int i = 0; i < DEP; i++) begin
        if (i == 3) begin
          chk(REG_FIFO_CNT_L, 8'(DEP - 3));
        end
        chk(REG_FIFO_DATA, gv[63 - 8 * ((off + i) % fb) -: 8]);
      end
      chk(REG_FIFO_DATA, 8'h00);
      chk(REG_FIFO_CNT_L, 8'h00);
    end
    wr(REG_INT_CFG, 8'h02);
    wr(REG_INT_EN, 8'h1F);
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      settle(2);
      cmp8({7'h0, o_int}, 8'h01);
      chk(REG_INT_STATUS, (k == 0) ? 8'h08 : (k == 1) ? 8'h10 : 8'h04);
      settle(2);
      cmp8({7'h0, o_int}, 8'h00);
    end
    wr(REG_INT_EN, 8'h0F);
    pulse(1);
    settle(2);
    cmp8({7'h0, o_int}, 8'h00);
    chk(REG_INT_STATUS, 8'h10);
    wr(REG_INT_CFG, 8'h0E);
    settle(2);
    cmp8({7'h0, o_int_oe}, 8'h00);
    pulse(0);
    settle(2);
    cmp8({6'h00, o_int, o_int_oe}, 8'h01);
    chk(REG_INT_STATUS, 8'h08);
    wr(REG_INT_CFG, 8'h00);
    pulse(2);
    settle(2);
    cmp8({7'h0, o_int}, 8'h01);
    settle(30);
    cmp8({7'h0, o_int}, 8'h01);
    settle(25);
    cmp8({7'h0, o_int}, 8'h00);
    ce <= 1'b0;
    wr(REG_INT_EN, 8'h00);
    ce <= 1'b1;
    chk(REG_INT_EN, 8'h0F);
    end_of_test();
  end
endmodule
